// [ptpcfg_pkg.sv]
// package of offsets, fields, reset values and encodings for the ptp timestamp config block
// Behaviour
// - low address register supplies bits 31:0 of 48-bit auxiliary address, resets zero.
// - auxiliary address detects ptp on a port only while its enable bit set.
// - port 2 master: capture on sync transmit and delay_req receive.
// - port 2 slave (reset): capture on delay_req transmit and sync receive.
// - bit 23 selects port 1 master or slave the same way, reset slave.
// - bit 30 enables 01:00:5E:00:01:81 on port 2, set after reset.
// - bits 29..27 enable alternates ...82, ...83, ...84 on port 2, reset zero.
// - bit 26 enables auxiliary address on port 2, reset zero.
// - port 2 receive lock (reset set) blocks receive capture while receive interrupt pending.
// - port 2 transmit lock (reset set) blocks transmit capture while transmit interrupt pending.
// - bit 22 enables primary address on port 1, set after reset.
// - bits 21..19 enable first, second, third alternates on port 1, reset zero.
// - bit 18 enables auxiliary address on port 1, reset zero.
// - high register bits 15:0 supply upper address bits, reset zero, 31:16 read zero.
// - bits 17 and 16 are port 1 receive and transmit locks, set after reset.
package ptpcfg_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] ADDR_AUX_HIGH    = 12'h018C;
  localparam logic [11:0] ADDR_AUX_LOW     = 12'h0190;
  localparam logic [11:0] ADDR_PORT_CONFIG = 12'h0194;
  localparam logic [11:0] ADDR_CAPTURE     = 12'h0198;

  localparam logic [31:0] AUX_HIGH_RESET   = 32'h0000_0000;
  localparam logic [31:0] AUX_LOW_RESET    = 32'h0000_0000;
  localparam logic [31:0] CONFIG_RESET     = 32'h4343_0000;
  localparam logic [31:0] CONFIG_MASK      = 32'hFFFF_0000;
  localparam logic [31:0] AUX_HIGH_MASK    = 32'h0000_FFFF;

  // ****************************************
  // config field positions
  // ****************************************
  localparam int P2_BASE   = 24;
  localparam int P1_BASE   = 16;
  localparam int F_MASTER  = 7;
  localparam int F_PRI     = 6;
  localparam int F_ALT1    = 5;
  localparam int F_ALT2    = 4;
  localparam int F_ALT3    = 3;
  localparam int F_AUX     = 2;
  localparam int F_LOCK_RX = 1;
  localparam int F_LOCK_TX = 0;

  // capture status register fields: pending bits per port, write one to clear
  localparam int S_P1_RX   = 0;
  localparam int S_P1_TX   = 1;
  localparam int S_P2_RX   = 2;
  localparam int S_P2_TX   = 3;

  // ****************************************
  // ptp multicast destinations
  // ****************************************
  localparam logic [47:0] MAC_PRIMARY = 48'h0100_5E00_0181;
  localparam logic [47:0] MAC_ALT1    = 48'h0100_5E00_0182;
  localparam logic [47:0] MAC_ALT2    = 48'h0100_5E00_0183;
  localparam logic [47:0] MAC_ALT3    = 48'h0100_5E00_0184;

  // ptp message types seen on the capture path
  localparam logic [3:0] MSG_SYNC      = 4'h0;
  localparam logic [3:0] MSG_DELAY_REQ = 4'h1;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    PTPCFG_IDLE = 2'b00,
    PTPCFG_RESP = 2'b01
  } ptpcfg_bus_state_t;

endpackage

// [ptpcfg_port_filter.sv]
// per-port ptp address match and capture gating
`timescale 1ns/1ps
module ptpcfg_port_filter (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // port settings
  input  wire logic [7:0]  port_cfg_i,
  input  wire logic [47:0] aux_addr_i,
  // frame observation
  input  wire logic        frame_valid_i,
  input  wire logic        frame_is_tx_i,
  input  wire logic [47:0] frame_dest_i,
  input  wire logic [3:0]  frame_msg_i,
  // pending capture flags
  input  wire logic        rx_pending_i,
  input  wire logic        tx_pending_i,
  // results
  output logic             is_ptp_o,
  output logic             capture_rx_o,
  output logic             capture_tx_o
);

  logic addr_hit;
  logic want_capture;
  logic is_master;

  // ****************************************
  // address match
  // ****************************************
  always_comb begin
    addr_hit = 1'b0;
    if (port_cfg_i[ptpcfg_pkg::F_PRI] && frame_dest_i == ptpcfg_pkg::MAC_PRIMARY) begin
      addr_hit = 1'b1;
    end
    if (port_cfg_i[ptpcfg_pkg::F_ALT1] && frame_dest_i == ptpcfg_pkg::MAC_ALT1) begin
      addr_hit = 1'b1;
    end
    if (port_cfg_i[ptpcfg_pkg::F_ALT2] && frame_dest_i == ptpcfg_pkg::MAC_ALT2) begin
      addr_hit = 1'b1;
    end
    if (port_cfg_i[ptpcfg_pkg::F_ALT3] && frame_dest_i == ptpcfg_pkg::MAC_ALT3) begin
      addr_hit = 1'b1;
    end
    if (port_cfg_i[ptpcfg_pkg::F_AUX] && frame_dest_i == aux_addr_i) begin
      addr_hit = 1'b1;
    end
  end

  // ****************************************
  // capture event selection
  // ****************************************
  always_comb begin
    is_master = port_cfg_i[ptpcfg_pkg::F_MASTER];
    if (is_master) begin
      want_capture = frame_is_tx_i ? (frame_msg_i == ptpcfg_pkg::MSG_SYNC)
                                   : (frame_msg_i == ptpcfg_pkg::MSG_DELAY_REQ);
    end else begin
      want_capture = frame_is_tx_i ? (frame_msg_i == ptpcfg_pkg::MSG_DELAY_REQ)
                                   : (frame_msg_i == ptpcfg_pkg::MSG_SYNC);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      is_ptp_o     <= 1'b0;
      capture_rx_o <= 1'b0;
      capture_tx_o <= 1'b0;
    end else begin
      is_ptp_o     <= frame_valid_i && addr_hit;
      // lock holds off a new capture only while the earlier one is still pending
      capture_rx_o <= frame_valid_i && addr_hit && want_capture && !frame_is_tx_i &&
                      !(port_cfg_i[ptpcfg_pkg::F_LOCK_RX] && rx_pending_i);
      capture_tx_o <= frame_valid_i && addr_hit && want_capture && frame_is_tx_i &&
                      !(port_cfg_i[ptpcfg_pkg::F_LOCK_TX] && tx_pending_i);
    end
  end

endmodule // ptpcfg_port_filter

// [ptpcfg_top.sv]
// ptp timestamp port configuration registers with axi4-lite slave
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ptpcfg_top (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [11:0] s_axi_awaddr_i,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  // axi4-lite write response
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  output logic [1:0]       s_axi_bresp_o,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  input  wire logic [11:0] s_axi_araddr_i,
  // axi4-lite read data
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  // port 1 frame observation
  input  wire logic        p1_frame_valid_i,
  input  wire logic        p1_frame_is_tx_i,
  input  wire logic [47:0] p1_frame_dest_i,
  input  wire logic [3:0]  p1_frame_msg_i,
  // port 2 frame observation
  input  wire logic        p2_frame_valid_i,
  input  wire logic        p2_frame_is_tx_i,
  input  wire logic [47:0] p2_frame_dest_i,
  input  wire logic [3:0]  p2_frame_msg_i,
  // capture results
  output logic             p1_is_ptp_o,
  output logic             p1_capture_rx_o,
  output logic             p1_capture_tx_o,
  output logic             p2_is_ptp_o,
  output logic             p2_capture_rx_o,
  output logic             p2_capture_tx_o
);

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] aux_high_reg;
  logic [31:0] aux_low_reg;
  logic [31:0] config_reg;
  logic [3:0]  pending_reg;
  logic [3:0]  pending_next;

  logic        aw_held_reg;
  logic [11:0] aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  logic        wr_hit;
  logic [31:0] wr_mask;
  logic [31:0] rd_data;
  logic        rd_hit;

  logic [47:0] aux_addr;
  logic [3:0]  capture_evt;
  logic        p1_cap_rx;
  logic        p1_cap_tx;
  logic        p2_cap_rx;
  logic        p2_cap_tx;

  assign aux_addr = {aux_high_reg[15:0], aux_low_reg};

  // ****************************************
  // write channel capture
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_reg     <= 1'b0;
      aw_addr_reg     <= 12'h000;
      s_axi_awready_o <= 1'b0;
    end else begin
      s_axi_awready_o <= !aw_held_reg && !s_axi_awready_o && !s_axi_bvalid_o;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_held_reg     <= 1'b0;
      w_data_reg     <= 32'h0000_0000;
      w_strb_reg     <= 4'h0;
      s_axi_wready_o <= 1'b0;
    end else begin
      s_axi_wready_o <= !w_held_reg && !s_axi_wready_o && !s_axi_bvalid_o;
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid_o;

  // byte lanes into a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wr_mask[gi*8 +: 8] = {8{w_strb_reg[gi]}};
    end
  endgenerate

  always_comb begin
    unique case (aw_addr_reg[11:2])
      ptpcfg_pkg::ADDR_AUX_HIGH[11:2]:    wr_hit = 1'b1;
      ptpcfg_pkg::ADDR_AUX_LOW[11:2]:     wr_hit = 1'b1;
      ptpcfg_pkg::ADDR_PORT_CONFIG[11:2]: wr_hit = 1'b1;
      ptpcfg_pkg::ADDR_CAPTURE[11:2]:     wr_hit = 1'b1;
      default:                            wr_hit = 1'b0;
    endcase
  end

  // ****************************************
  // register storage
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aux_low_reg <= ptpcfg_pkg::AUX_LOW_RESET;
    end else if (wr_fire && aw_addr_reg[11:2] == ptpcfg_pkg::ADDR_AUX_LOW[11:2]) begin
      aux_low_reg <= (aux_low_reg & ~wr_mask) | (w_data_reg & wr_mask);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aux_high_reg <= ptpcfg_pkg::AUX_HIGH_RESET;
    end else if (wr_fire && aw_addr_reg[11:2] == ptpcfg_pkg::ADDR_AUX_HIGH[11:2]) begin
      aux_high_reg <= ((aux_high_reg & ~wr_mask) | (w_data_reg & wr_mask))
                      & ptpcfg_pkg::AUX_HIGH_MASK;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      config_reg <= ptpcfg_pkg::CONFIG_RESET;
    end else if (wr_fire && aw_addr_reg[11:2] == ptpcfg_pkg::ADDR_PORT_CONFIG[11:2]) begin
      config_reg <= ((config_reg & ~wr_mask) | (w_data_reg & wr_mask))
                    & ptpcfg_pkg::CONFIG_MASK;
    end
  end

  // ****************************************
  // capture pending flags
  // ****************************************
  assign capture_evt[ptpcfg_pkg::S_P1_RX] = p1_cap_rx;
  assign capture_evt[ptpcfg_pkg::S_P1_TX] = p1_cap_tx;
  assign capture_evt[ptpcfg_pkg::S_P2_RX] = p2_cap_rx;
  assign capture_evt[ptpcfg_pkg::S_P2_TX] = p2_cap_tx;

  always_comb begin
    pending_next = pending_reg;
    if (wr_fire && aw_addr_reg[11:2] == ptpcfg_pkg::ADDR_CAPTURE[11:2] && w_strb_reg[0]) begin
      pending_next = pending_reg & ~w_data_reg[3:0];
    end
    pending_next = pending_next | capture_evt; // set wins over clear
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending_reg <= 4'h0;
    end else begin
      pending_reg <= pending_next;
    end
  end

  // ****************************************
  // write response
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= ptpcfg_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_hit ? ptpcfg_pkg::RESP_OKAY : ptpcfg_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (s_axi_araddr_i[11:2])
      ptpcfg_pkg::ADDR_AUX_HIGH[11:2]:    rd_data = aux_high_reg;
      ptpcfg_pkg::ADDR_AUX_LOW[11:2]:     rd_data = aux_low_reg;
      ptpcfg_pkg::ADDR_PORT_CONFIG[11:2]: rd_data = config_reg;
      ptpcfg_pkg::ADDR_CAPTURE[11:2]:     rd_data = {28'h000_0000, pending_reg};
      default:                            rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= ptpcfg_pkg::RESP_OKAY;
    end else begin
      s_axi_arready_o <= !s_axi_arready_o && !s_axi_rvalid_o;
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= rd_data;
        s_axi_rresp_o   <= rd_hit ? ptpcfg_pkg::RESP_OKAY : ptpcfg_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
      end
    end
  end

  // ****************************************
  // per-port filters
  // ****************************************
  ptpcfg_port_filter u_port1 (
    .clk_sys_i     (clk_sys_i),
    .rst_n_i       (rst_n_i),
    .port_cfg_i    (config_reg[ptpcfg_pkg::P1_BASE +: 8]),
    .aux_addr_i    (aux_addr),
    .frame_valid_i (p1_frame_valid_i),
    .frame_is_tx_i (p1_frame_is_tx_i),
    .frame_dest_i  (p1_frame_dest_i),
    .frame_msg_i   (p1_frame_msg_i),
    .rx_pending_i  (pending_reg[ptpcfg_pkg::S_P1_RX]),
    .tx_pending_i  (pending_reg[ptpcfg_pkg::S_P1_TX]),
    .is_ptp_o      (p1_is_ptp_o),
    .capture_rx_o  (p1_cap_rx),
    .capture_tx_o  (p1_cap_tx)
  );

  ptpcfg_port_filter u_port2 (
    .clk_sys_i     (clk_sys_i),
    .rst_n_i       (rst_n_i),
    .port_cfg_i    (config_reg[ptpcfg_pkg::P2_BASE +: 8]),
    .aux_addr_i    (aux_addr),
    .frame_valid_i (p2_frame_valid_i),
    .frame_is_tx_i (p2_frame_is_tx_i),
    .frame_dest_i  (p2_frame_dest_i),
    .frame_msg_i   (p2_frame_msg_i),
    .rx_pending_i  (pending_reg[ptpcfg_pkg::S_P2_RX]),
    .tx_pending_i  (pending_reg[ptpcfg_pkg::S_P2_TX]),
    .is_ptp_o      (p2_is_ptp_o),
    .capture_rx_o  (p2_cap_rx),
    .capture_tx_o  (p2_cap_tx)
  );

  assign p1_capture_rx_o = p1_cap_rx;
  assign p1_capture_tx_o = p1_cap_tx;
  assign p2_capture_rx_o = p2_cap_rx;
  assign p2_capture_tx_o = p2_cap_tx;

endmodule // ptpcfg_top

// [ptpcfg_sva.sv]
// checker of bus and capture timing for the ptp timestamp config block
`timescale 1ns/1ps
module ptpcfg_sva (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // register bus
  input  wire logic        s_axi_awvalid_i,
  input  wire logic        s_axi_awready_o,
  input  wire logic        s_axi_wvalid_i,
  input  wire logic        s_axi_wready_o,
  input  wire logic        s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [1:0]  s_axi_bresp_o,
  input  wire logic        s_axi_arvalid_i,
  input  wire logic        s_axi_arready_o,
  input  wire logic        s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic [31:0] s_axi_rdata_o,
  // frame paths
  input  wire logic        p1_frame_valid_i,
  input  wire logic        p1_frame_is_tx_i,
  input  wire logic        p2_frame_valid_i,
  input  wire logic        p2_frame_is_tx_i,
  input  wire logic        p1_is_ptp_o,
  input  wire logic        p1_capture_rx_o,
  input  wire logic        p1_capture_tx_o,
  input  wire logic        p2_is_ptp_o,
  input  wire logic        p2_capture_rx_o,
  input  wire logic        p2_capture_tx_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // ****************************************
  // sequences
  // ****************************************
  sequence s_wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence

  // ****************************************
  // properties
  // ****************************************
  // both halves are held one cycle before the register update raises the response
  property p_wr_resp;   s_wr_taken |-> ##2 s_axi_bvalid_o; endproperty
  property p_b_hold;    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o); endproperty
  property p_rd_resp;   s_rd_taken |=> s_axi_rvalid_o; endproperty
  property p_r_hold;    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
  property p_refuse;    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
  property p_p2_rx;     p2_capture_rx_o |-> p2_is_ptp_o && $past(p2_frame_valid_i && !p2_frame_is_tx_i); endproperty
  property p_p2_tx;     p2_capture_tx_o |-> p2_is_ptp_o && $past(p2_frame_valid_i && p2_frame_is_tx_i); endproperty
  property p_p1_rx;     p1_capture_rx_o |-> p1_is_ptp_o && $past(p1_frame_valid_i && !p1_frame_is_tx_i); endproperty
  property p_p1_tx;     p1_capture_tx_o |-> p1_is_ptp_o && $past(p1_frame_valid_i && p1_frame_is_tx_i); endproperty
  property p_ptp_src;   p2_is_ptp_o |-> $past(p2_frame_valid_i); endproperty

  a_wr_resp: assert property (p_wr_resp) else $error("no write response after write");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  a_rd_resp: assert property (p_rd_resp) else $error("no read data after read");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  a_refuse: assert property (p_refuse) else $error("write taken while response open");
  a_p2_rx: assert property (p_p2_rx) else $error("port 2 rx capture without rx frame");
  a_p2_tx: assert property (p_p2_tx) else $error("port 2 tx capture without tx frame");
  a_p1_rx: assert property (p_p1_rx) else $error("port 1 rx capture without rx frame");
  a_p1_tx: assert property (p_p1_tx) else $error("port 1 tx capture without tx frame");
  a_ptp_src: assert property (p_ptp_src) else $error("port 2 match without frame");
endmodule // ptpcfg_sva

// [ptpcfg_top_bench.sv]
// self-checking bench for the ptp timestamp config block
`timescale 1ns/1ps
module ptpcfg_top_bench;
  // ****************************************
  // signals
  // ****************************************
  typedef struct packed {
    logic [31:0] cfg;
    logic        p2;
    logic        tx;
    logic [47:0] dest;
    logic [3:0]  msg;
    logic [2:0]  exp;
  } ptpcfg_row_t;
  localparam logic [47:0] AUX = 48'h1234_9abc_def0;
  localparam logic [47:0] PRI = ptpcfg_pkg::MAC_PRIMARY;
  localparam logic [47:0] A1  = ptpcfg_pkg::MAC_ALT1;
  localparam logic [47:0] A2  = ptpcfg_pkg::MAC_ALT2;
  localparam logic [47:0] A3  = ptpcfg_pkg::MAC_ALT3;
  localparam logic [3:0]  SY  = 4'h0;
  localparam logic [3:0]  DR  = 4'h1;
  logic        clk_sys_i, rst_n_i;
  logic        s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i, p1_frame_msg_i, p2_frame_msg_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic        p1_frame_valid_i, p1_frame_is_tx_i, p2_frame_valid_i, p2_frame_is_tx_i;
  logic [47:0] p1_frame_dest_i, p2_frame_dest_i;
  logic        p1_is_ptp_o, p1_capture_rx_o, p1_capture_tx_o;
  logic        p2_is_ptp_o, p2_capture_rx_o, p2_capture_tx_o;
  int          n_errors, compares, cycles;
  ptpcfg_row_t rows [19];

  ptpcfg_top uut (.*);

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic complete_run();
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_sys_i);
    s_axi_awvalid_i <= 1'b1;
    s_axi_awaddr_i <= a;
    s_axi_wvalid_i <= 1'b1;
    s_axi_wdata_i <= d;
    s_axi_bready_i <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys_i);
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_ok = 1'b1;
        s_axi_awvalid_i <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_ok = 1'b1;
        s_axi_wvalid_i <= 1'b0;
      end
    end
    do @(posedge clk_sys_i); while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    chk("bresp", 32'(s_axi_bresp_o), 32'(er));
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_sys_i);
    s_axi_arvalid_i <= 1'b1;
    s_axi_araddr_i <= a;
    s_axi_rready_i <= 1'b1;
    do @(posedge clk_sys_i); while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge clk_sys_i); while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
    chk("rdata", s_axi_rdata_o, ed);
    chk("rresp", 32'(s_axi_rresp_o), 32'(er));
  endtask

  task automatic frame(input logic p2, input logic tx, input logic [47:0] d,
                       input logic [3:0] m, input logic [2:0] e);
    @(posedge clk_sys_i);
    if (p2) begin
      p2_frame_valid_i <= 1'b1;
      p2_frame_is_tx_i <= tx;
      p2_frame_dest_i <= d;
      p2_frame_msg_i <= m;
    end else begin
      p1_frame_valid_i <= 1'b1;
      p1_frame_is_tx_i <= tx;
      p1_frame_dest_i <= d;
      p1_frame_msg_i <= m;
    end
    @(posedge clk_sys_i);
    p1_frame_valid_i <= 1'b0;
    p2_frame_valid_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("port hit", 32'(p2 ? {p2_is_ptp_o, p2_capture_rx_o, p2_capture_tx_o}
                           : {p1_is_ptp_o, p1_capture_rx_o, p1_capture_tx_o}), 32'(e));
    chk("other port", 32'(p2 ? {p1_is_ptp_o, p1_capture_rx_o, p1_capture_tx_o}
                             : {p2_is_ptp_o, p2_capture_rx_o, p2_capture_tx_o}), 32'h0000_0000);
  endtask

  task automatic rst_chk();
    rd(12'h18c, 32'h0000_0000, 2'b00);
    rd(12'h190, 32'h0000_0000, 2'b00);
    rd(12'h194, 32'h4343_0000, 2'b00);
  endtask

  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i} = '0;
    {s_axi_rready_i, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
    s_axi_wstrb_i = 4'hf;
    {p1_frame_valid_i, p1_frame_is_tx_i, p1_frame_dest_i, p1_frame_msg_i} = '0;
    {p2_frame_valid_i, p2_frame_is_tx_i, p2_frame_dest_i, p2_frame_msg_i} = '0;
    {n_errors, compares, cycles} = '0;
    rows = '{'{32'h4000_0000, 1'b1, 1'b0, PRI, SY, 3'b110}, '{32'h4000_0000, 1'b1, 1'b1, PRI, SY, 3'b100},
             '{32'h4000_0000, 1'b1, 1'b1, PRI, DR, 3'b101}, '{32'hc000_0000, 1'b1, 1'b1, PRI, SY, 3'b101},
             '{32'hc000_0000, 1'b1, 1'b0, PRI, DR, 3'b110}, '{32'hc000_0000, 1'b1, 1'b0, PRI, SY, 3'b100},
             '{32'h2000_0000, 1'b1, 1'b0, A1, SY, 3'b110}, '{32'h2000_0000, 1'b1, 1'b0, PRI, SY, 3'b000},
             '{32'h1000_0000, 1'b1, 1'b0, A2, SY, 3'b110}, '{32'h0800_0000, 1'b1, 1'b0, A3, SY, 3'b110},
             '{32'h0400_0000, 1'b1, 1'b0, AUX, SY, 3'b110}, '{32'h2000_0000, 1'b1, 1'b0, AUX, SY, 3'b000},
             '{32'h0040_0000, 1'b0, 1'b0, PRI, SY, 3'b110}, '{32'h00c0_0000, 1'b0, 1'b1, PRI, SY, 3'b101},
             '{32'h0020_0000, 1'b0, 1'b0, A1, SY, 3'b110}, '{32'h0010_0000, 1'b0, 1'b0, A2, SY, 3'b110},
             '{32'h0008_0000, 1'b0, 1'b0, A3, SY, 3'b110}, '{32'h0004_0000, 1'b0, 1'b0, AUX, SY, 3'b110},
             '{32'h0400_0000, 1'b0, 1'b0, AUX, SY, 3'b000}};
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rst_chk();
    wr(12'h190, 32'h9abc_def0, 2'b00);
    wr(12'h18c, 32'hffff_1234, 2'b00);
    rd(12'h18c, 32'h0000_1234, 2'b00);
    rd(12'h190, 32'h9abc_def0, 2'b00);
    wr(12'h194, 32'hffff_ffff, 2'b00);
    rd(12'h194, 32'hffff_0000, 2'b00);
    wr(12'h1a0, 32'h1234_5678, 2'b10);
    rd(12'h1a0, 32'h0000_0000, 2'b10);
    foreach (rows[i]) begin
      wr(12'h194, rows[i].cfg, 2'b00);
      frame(rows[i].p2, rows[i].tx, rows[i].dest, rows[i].msg, rows[i].exp);
    end
    // capture locks hold while pending, release once cleared
    wr(12'h194, 32'h4300_0000, 2'b00);
    wr(12'h198, 32'h0000_000f, 2'b00);
    frame(1'b1, 1'b0, PRI, SY, 3'b110);
    frame(1'b1, 1'b0, PRI, SY, 3'b100);
    rd(12'h198, 32'h0000_0004, 2'b00);
    wr(12'h198, 32'h0000_0004, 2'b00);
    frame(1'b1, 1'b0, PRI, SY, 3'b110);
    frame(1'b1, 1'b1, PRI, DR, 3'b101);
    frame(1'b1, 1'b1, PRI, DR, 3'b100);
    wr(12'h194, 32'h0043_0000, 2'b00);
    frame(1'b0, 1'b0, PRI, SY, 3'b110);
    frame(1'b0, 1'b0, PRI, SY, 3'b100);
    wr(12'h194, 32'h4000_0000, 2'b00);
    frame(1'b1, 1'b0, PRI, SY, 3'b110);
    // reset in mid-run restores both address registers and the config register
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rst_chk();
    complete_run();
  end
endmodule // ptpcfg_top_bench

bind ptpcfg_top ptpcfg_sva chk_i (
  .clk_sys_i, .rst_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .p1_frame_valid_i, .p1_frame_is_tx_i,
  .p2_frame_valid_i, .p2_frame_is_tx_i, .p1_is_ptp_o, .p1_capture_rx_o, .p1_capture_tx_o,
  .p2_is_ptp_o, .p2_capture_rx_o, .p2_capture_tx_o
);
